/* File: verilog/display_ctrl_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts of the display control registers
// Assumes: register index times four gives the AXI byte address
// Notes:   definitions only
`ifndef DISPLAY_CTRL_CONSTS_SVH
`define DISPLAY_CTRL_CONSTS_SVH

// register indexes
`define DC_IDX_ENABLE     18'h08009
`define DC_IDX_ATTRIBUTE  18'h0800a
`define DC_IDX_START_LOW  18'h0800b
`define DC_IDX_START_HIGH 18'h0800c
`define DC_IDX_LINE_COUNT 18'h0800d
`define DC_IDX_MODE       18'h08030
`define DC_IDX_STATUS     18'h08031

// field positions
`define DC_ENABLE_BIT     0
`define DC_CURSOR_LSB     0
`define DC_BLOCK1_LSB     2
`define DC_BLOCK2_LSB     4
`define DC_BLOCK3_LSB     6
`define DC_MODE_DUAL_BIT  0
`define DC_MODE_PSAVE_BIT 1

// reset values
`define DC_RESET_VALUE    8'h00

// flash timing: frame counter bit that sets each half period, cursor on counts in frames
`define DC_SLOW_HALF_BIT  4
`define DC_FAST_HALF_BIT  1
`define DC_CUR_SLOW_ON    5'h16
`define DC_CUR_VSLOW_ON   6'h2d

// bus answers
`define DC_RESP_OKAY      2'b00
`define DC_RESP_SLVERR    2'b10

`endif

/* File: verilog/display_ctrl_pkg.sv */
// Purpose: types shared by the display control register bank
// Assumes: nothing
// Notes:   constants live in display_ctrl_consts.svh
package display_ctrl_pkg;
  typedef logic [7:0] reg8_t;
  typedef enum logic [1:0] {ATTR_BLANK, ATTR_STEADY, ATTR_SLOW, ATTR_FAST} attr_e;
  typedef enum logic [1:0] {PARAM_IDLE, PARAM_SWITCH, PARAM_SCROLL} param_e;
endpackage

/* File: verilog/display_control_regs.sv */
// Purpose: display control register bank over AXI4-Lite with attribute flashing and cursor tracking
// Assumes: framePulse, memory strobes and command strobes are one-cycle pulses on sys_clk
// Notes:   all flash rates derive from a free-running frame counter
// How it works
// R1: display enable bit 0 turns the whole output on or off
// R2: a cleared enable blanks every block and the cursor regardless of attributes
// R3: block 3 field bits 7-6: blank, steady, flash frame/32, flash frame/4
// R4: block 2 field bits 5-4 uses the same four-way encoding
// R5: in dual panel mode block 4 follows the block 2 field
// R6: block 1 field bits 3-2: blank, steady, flash frame/32, flash frame/4
// R7: cursor field bits 1-0: blank, steady, flash frame/32, flash frame/64
// R8: a flashing cursor is visible 70 percent and hidden 30 percent
// R9: a memory write re-enables a disabled cursor and advances its position
// R10: a memory read advances the cursor but leaves it disabled
// R11: block 1 start address is 16 bits, low byte then high byte register
// R12: the host writes the low byte before the high byte
// R13: the used start address changes only when the high byte is written
// R14: the block 1 size field means lines minus one
// R15: the display switch command parameter loads the attribute register
// R16: scroll command parameters load start and size registers in register order
// R17: all registers reset to zero and are readable and writable; a write to the status register is answered OKAY but changes nothing
// R18: entering power save clears the display enable bit
// R19: blocks flash from a frame counter with an even on/off split
`timescale 1ns/1ps
`include "display_ctrl_consts.svh"
`default_nettype none

module display_control_regs (
  // clock and reset
  input  wire  logic                   sys_clk,
  input  wire  logic                   rst,
  // axi4-lite write
  input  wire  logic                   s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire  logic [19:0]            s_axi_awaddr,
  input  wire  logic                   s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire  logic [31:0]            s_axi_wdata,
  input  wire  logic [3:0]             s_axi_wstrb,
  output logic                         s_axi_bvalid,
  input  wire  logic                   s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // axi4-lite read
  input  wire  logic                   s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire  logic [19:0]            s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire  logic                   s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // indirect command path
  input  wire  logic                   displaySwitchCommand,
  input  wire  logic                   scrollCommand,
  input  wire  logic                   paramStrobe,
  input  wire  display_ctrl_pkg::reg8_t paramData,
  // display memory access and timing
  input  wire  logic                   memWrite,
  input  wire  logic                   memRead,
  input  wire  logic                   cursorSet,
  input  wire  logic [15:0]            cursorSetAddress,
  input  wire  logic                   framePulse,
  // display outputs
  output logic                         displayOn,
  output logic                         block1Visible,
  output logic                         block2Visible,
  output logic                         block3Visible,
  output logic                         block4Visible,
  output logic                         cursorVisible,
  output logic [15:0]                  block1StartAddress,
  output logic [8:0]                   block1Lines,
  output logic [15:0]                  cursorAddress,
  output logic                         powerSave
);
  import display_ctrl_pkg::*;

  reg8_t       dispEnable, attribute, startLow, startHigh, lineCount, modeReg;
  logic [5:0]  frameCnt;
  param_e      paramState;
  logic [1:0]  paramIndex;
  logic [17:0] wrIdx, rdIdx;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        awHave, wHave, wrEn, wrByte, wrHit;
  logic        psavePrev, psaveEnter;
  logic        paramSwitch, paramLow, paramHigh, paramLines;
  logic        next_block1, next_block2, next_block3, next_cursor;

  // ---------------- axi4-lite write side ----------------
  assign s_axi_awready = !awHave && !s_axi_bvalid;
  assign s_axi_wready  = !wHave && !s_axi_bvalid;
  assign wrEn          = awHave && wHave && !s_axi_bvalid;
  assign wrByte        = wrEn && wrStrb[0];

  always_comb begin
    case (wrIdx)
      `DC_IDX_ENABLE, `DC_IDX_ATTRIBUTE, `DC_IDX_START_LOW, `DC_IDX_START_HIGH,
      `DC_IDX_LINE_COUNT, `DC_IDX_MODE, `DC_IDX_STATUS: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHave <= 1'b0;
      wrIdx  <= 18'h00000;
    end else if (wrEn) begin
      awHave <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHave <= 1'b1;
      wrIdx  <= s_axi_awaddr[19:2];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wHave  <= 1'b0;
      wrData <= 32'h00000000;
      wrStrb <= 4'h0;
    end else if (wrEn) begin
      wHave <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHave  <= 1'b1;
      wrData <= s_axi_wdata;
      wrStrb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DC_RESP_OKAY;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? `DC_RESP_OKAY : `DC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- indirect command parameters ----------------
  assign paramSwitch = paramStrobe && paramState == PARAM_SWITCH && paramIndex == 2'd0;
  assign paramLow    = paramStrobe && paramState == PARAM_SCROLL && paramIndex == 2'd0;
  assign paramHigh   = paramStrobe && paramState == PARAM_SCROLL && paramIndex == 2'd1;
  assign paramLines  = paramStrobe && paramState == PARAM_SCROLL && paramIndex == 2'd2;

  // later scroll parameters belong to other blocks; after the third the state returns to idle and ignores them
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      paramState <= PARAM_IDLE;
      paramIndex <= 2'd0;
    end else if (displaySwitchCommand) begin
      paramState <= PARAM_SWITCH;
      paramIndex <= 2'd0;
    end else if (scrollCommand) begin
      paramState <= PARAM_SCROLL;
      paramIndex <= 2'd0;
    end else if (paramStrobe) begin
      case (paramState)
        PARAM_SWITCH: paramState <= PARAM_IDLE;
        PARAM_SCROLL: begin
          if (paramIndex == 2'd2) begin
            paramState <= PARAM_IDLE;
          end
          paramIndex <= paramIndex + 2'd1;
        end
        default: paramState <= PARAM_IDLE;
      endcase
    end
  end

  // ---------------- registers ----------------
  assign psaveEnter = modeReg[`DC_MODE_PSAVE_BIT] && !psavePrev;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modeReg   <= `DC_RESET_VALUE; // R17
      psavePrev <= 1'b0;
    end else begin
      psavePrev <= modeReg[`DC_MODE_PSAVE_BIT];
      if (wrByte && wrIdx == `DC_IDX_MODE) begin
        modeReg <= {6'h00, wrData[1:0]};
      end
    end
  end

  // a software write in the same cycle as power save entry wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dispEnable <= `DC_RESET_VALUE; // R17
    end else if (wrByte && wrIdx == `DC_IDX_ENABLE) begin
      dispEnable <= {7'h00, wrData[`DC_ENABLE_BIT]}; // R1
    end else if (psaveEnter) begin
      dispEnable <= `DC_RESET_VALUE; // R18
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      attribute <= `DC_RESET_VALUE; // R17
    end else if (wrByte && wrIdx == `DC_IDX_ATTRIBUTE) begin
      attribute <= wrData[7:0];
    end else if (paramSwitch) begin
      attribute <= paramData; // R15
    end else if (memWrite && attribute[1:0] == ATTR_BLANK) begin
      attribute[1:0] <= ATTR_STEADY; // R9
    end
  end

  // the low byte is only staged; the used address moves with the high byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      startLow           <= `DC_RESET_VALUE;
      startHigh          <= `DC_RESET_VALUE;
      block1StartAddress <= 16'h0000;
    end else if (wrByte && wrIdx == `DC_IDX_START_LOW) begin
      startLow <= wrData[7:0]; // R11 R12
    end else if (wrByte && wrIdx == `DC_IDX_START_HIGH) begin
      startHigh          <= wrData[7:0];
      block1StartAddress <= {wrData[7:0], startLow}; // R13
    end else if (paramLow) begin
      startLow <= paramData; // R16
    end else if (paramHigh) begin
      startHigh          <= paramData;
      block1StartAddress <= {paramData, startLow}; // R13 R16
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lineCount   <= `DC_RESET_VALUE;
      block1Lines <= 9'h001;
    end else if (wrByte && wrIdx == `DC_IDX_LINE_COUNT) begin
      lineCount   <= wrData[7:0];
      block1Lines <= {1'b0, wrData[7:0]} + 9'h001; // R14
    end else if (paramLines) begin
      lineCount   <= paramData; // R16
      block1Lines <= {1'b0, paramData} + 9'h001; // R14
    end
  end

  // ---------------- cursor position ----------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cursorAddress <= 16'h0000;
    end else if (cursorSet) begin
      cursorAddress <= cursorSetAddress;
    end else if (memWrite || memRead) begin
      cursorAddress <= cursorAddress + 16'h0001; // R9 R10
    end
  end

  // ---------------- flash timing ----------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frameCnt <= 6'h00;
    end else if (framePulse) begin
      frameCnt <= frameCnt + 6'h01; // R19
    end
  end

  function automatic logic blockShown(input logic [1:0] field, input logic [5:0] cnt);
    case (attr_e'(field))
      ATTR_STEADY: blockShown = 1'b1;
      ATTR_SLOW:   blockShown = !cnt[`DC_SLOW_HALF_BIT]; // R19
      ATTR_FAST:   blockShown = !cnt[`DC_FAST_HALF_BIT];
      default:     blockShown = 1'b0;
    endcase
  endfunction

  always_comb begin
    next_block1 = dispEnable[`DC_ENABLE_BIT] && blockShown(attribute[3:2], frameCnt); // R2 R6
    next_block2 = dispEnable[`DC_ENABLE_BIT] && blockShown(attribute[5:4], frameCnt); // R2 R4
    next_block3 = dispEnable[`DC_ENABLE_BIT] && blockShown(attribute[7:6], frameCnt); // R2 R3
    case (attr_e'(attribute[1:0]))
      ATTR_STEADY: next_cursor = 1'b1;
      ATTR_SLOW:   next_cursor = frameCnt[4:0] < `DC_CUR_SLOW_ON; // R7 R8
      ATTR_FAST:   next_cursor = frameCnt < `DC_CUR_VSLOW_ON; // R7 R8
      default:     next_cursor = 1'b0;
    endcase
    next_cursor = next_cursor && dispEnable[`DC_ENABLE_BIT]; // R2
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      displayOn     <= 1'b0;
      block1Visible <= 1'b0;
      block2Visible <= 1'b0;
      block3Visible <= 1'b0;
      block4Visible <= 1'b0;
      cursorVisible <= 1'b0;
      powerSave     <= 1'b0;
    end else begin
      displayOn     <= dispEnable[`DC_ENABLE_BIT]; // R1
      block1Visible <= next_block1;
      block2Visible <= next_block2;
      block3Visible <= next_block3;
      block4Visible <= next_block2 && modeReg[`DC_MODE_DUAL_BIT]; // R5
      cursorVisible <= next_cursor;
      powerSave     <= modeReg[`DC_MODE_PSAVE_BIT];
    end
  end

  // ---------------- axi4-lite read side ----------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rdIdx         = s_axi_araddr[19:2];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `DC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `DC_RESP_OKAY;
      case (rdIdx)
        `DC_IDX_ENABLE:     s_axi_rdata <= {24'h000000, dispEnable}; // R17
        `DC_IDX_ATTRIBUTE:  s_axi_rdata <= {24'h000000, attribute};
        `DC_IDX_START_LOW:  s_axi_rdata <= {24'h000000, startLow};
        `DC_IDX_START_HIGH: s_axi_rdata <= {24'h000000, startHigh};
        `DC_IDX_LINE_COUNT: s_axi_rdata <= {24'h000000, lineCount};
        `DC_IDX_MODE:       s_axi_rdata <= {24'h000000, modeReg};
        `DC_IDX_STATUS:     s_axi_rdata <= {frameCnt, 2'h0, cursorAddress, 2'h0, block4Visible,
                                            block3Visible, block2Visible, block1Visible,
                                            cursorVisible, displayOn};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `DC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_disp_off;
    !dispEnable[0] |=> !block1Visible && !block2Visible && !block3Visible && !block4Visible && !cursorVisible;
  endproperty
  a_disp_off: assert property (p_disp_off) else $error("output visible while display disabled"); // R2

  property p_disp_on;
    dispEnable[0] |=> displayOn;
  endproperty
  a_disp_on: assert property (p_disp_on) else $error("display enable not followed"); // R1

  property p_cursor_duty;
    dispEnable[0] && attribute[1:0] == 2'b10 && frameCnt[4:0] >= 5'h16 |=> !cursorVisible;
  endproperty
  a_cursor_duty: assert property (p_cursor_duty) else $error("cursor shown in off part of flash"); // R8

  property p_block_slow;
    dispEnable[0] && attribute[3:2] == 2'b10 |=> block1Visible == !$past(frameCnt[4]);
  endproperty
  a_block_slow: assert property (p_block_slow) else $error("block 1 slow flash wrong"); // R6

  property p_block4;
    block4Visible |-> $past(modeReg[0]) && block2Visible;
  endproperty
  a_block4: assert property (p_block4) else $error("block 4 shown outside dual panel"); // R5

  property p_commit;
    wrByte && wrIdx == `DC_IDX_START_HIGH |=> block1StartAddress == {$past(wrData[7:0]), startLow};
  endproperty
  a_commit: assert property (p_commit) else $error("start address not committed on high byte"); // R13

  property p_low_keep;
    wrByte && wrIdx == `DC_IDX_START_LOW |=> $stable(block1StartAddress);
  endproperty
  a_low_keep: assert property (p_low_keep) else $error("start address moved on low byte"); // R13
  property p_auto_enable;
    memWrite && !cursorSet && attribute[1:0] == 2'b00 && !(wrByte && wrIdx == `DC_IDX_ATTRIBUTE) && !paramSwitch
      |=> attribute[1:0] == 2'b01 && cursorAddress == $past(cursorAddress) + 16'h0001;
  endproperty
  a_auto_enable: assert property (p_auto_enable) else $error("memory write did not restore cursor"); // R9
  property p_read_keep;
    memRead && !memWrite && !cursorSet && attribute[1:0] == 2'b00 && !(wrByte && wrIdx == `DC_IDX_ATTRIBUTE)
      && !paramSwitch |=> attribute[1:0] == 2'b00 && cursorAddress == $past(cursorAddress) + 16'h0001;
  endproperty
  a_read_keep: assert property (p_read_keep) else $error("memory read changed cursor enable"); // R10

  property p_lines;
    block1Lines == {1'b0, lineCount} + 9'h001;
  endproperty
  a_lines: assert property (p_lines) else $error("line count mismatch"); // R14

  property p_psave;
    psaveEnter && !(wrByte && wrIdx == `DC_IDX_ENABLE) |=> dispEnable == 8'h00;
  endproperty
  a_psave: assert property (p_psave) else $error("power save did not clear enable"); // R18

  c_scroll: cover property (paramHigh ##1 paramLines);
  c_cursor_flash: cover property (cursorVisible ##1 !cursorVisible && displayOn);
  c_write_resp: cover property (wrEn ##1 s_axi_bvalid && s_axi_bresp == 2'b00);
endmodule

`default_nettype wire

/* File: tb/display_host_model.sv */
// Purpose: host model driving the indirect command path of the register bank
// Assumes: command and parameter strobes are one-cycle pulses on sys_clk
// Notes:   released parameter data shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module display_host_model (
  // clock
  input  wire logic              sys_clk,
  // command path
  output logic                   displaySwitchCommand,
  output logic                   scrollCommand,
  output logic                   paramStrobe,
  output display_ctrl_pkg::reg8_t paramData
);
  import display_ctrl_pkg::*;
  initial begin
    displaySwitchCommand = 1'b0;
    scrollCommand = 1'b0;
    paramStrobe = 1'b0;
    paramData = 8'h00;
  end
  // scroll sends low byte, high byte, size; switch sends one attribute byte
  task automatic send(input logic scroll, input logic [23:0] bytes, input int n);
    @(posedge sys_clk);
    scrollCommand <= scroll;
    displaySwitchCommand <= !scroll;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      scrollCommand <= 1'b0;
      displaySwitchCommand <= 1'b0;
      paramStrobe <= 1'b1;
      paramData <= bytes[8*i +: 8];
    end
    @(posedge sys_clk);
    paramStrobe <= 1'b0;
    paramData <= ~paramData;
  endtask
endmodule
`default_nettype wire

/* File: tb/display_control_regs_tb_top.sv */
// Purpose: self-checking bench for the display control register bank
// Assumes: AXI byte address is the register index times four
// Notes:   visibility is sampled at the falling edge, after outputs settle
`timescale 1ns/1ps
`include "display_ctrl_consts.svh"
`default_nettype none
module display_control_regs_tb_top;
  import display_ctrl_pkg::*;
  localparam logic [19:0] A_EN = {`DC_IDX_ENABLE, 2'b00};
  localparam logic [19:0] A_AT = {`DC_IDX_ATTRIBUTE, 2'b00};
  localparam logic [19:0] A_LO = {`DC_IDX_START_LOW, 2'b00};
  localparam logic [19:0] A_HI = {`DC_IDX_START_HIGH, 2'b00};
  localparam logic [19:0] A_LN = {`DC_IDX_LINE_COUNT, 2'b00};
  localparam logic [19:0] A_MD = {`DC_IDX_MODE, 2'b00};
  localparam logic [19:0] A_ST = {`DC_IDX_STATUS, 2'b00};
  localparam logic [19:0] A_NO = 20'h20038;
  localparam logic [1:0]  OK = `DC_RESP_OKAY;
  localparam logic [1:0]  ERR = `DC_RESP_SLVERR;
  logic        sys_clk, rst, awValid, wValid, bReady, arValid, rReady;
  logic        memWrite, memRead, cursorSet, framePulse;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic        displaySwitchCommand, scrollCommand, paramStrobe;
  logic        displayOn, block1Visible, block2Visible, block3Visible;
  logic        block4Visible, cursorVisible, powerSave;
  logic [19:0] awAddr, arAddr;
  logic [31:0] wData, rData;
  logic [15:0] cursorSetAddress, block1StartAddress, cursorAddress;
  logic [1:0]  bResp, rResp;
  logic [3:0]  wStrb;
  logic [8:0]  block1Lines;
  reg8_t       paramData;
  int          errorCnt, totalChecks;
  logic [19:0] regs [5] = '{A_EN, A_AT, A_LO, A_HI, A_LN};

  display_control_regs display_control_regs_inst (
    .sys_clk, .rst, .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .displaySwitchCommand, .scrollCommand, .paramStrobe, .paramData, .memWrite, .memRead,
    .cursorSet, .cursorSetAddress, .framePulse, .displayOn, .block1Visible, .block2Visible,
    .block3Visible, .block4Visible, .cursorVisible, .block1StartAddress, .block1Lines,
    .cursorAddress, .powerSave);
  display_host_model display_host_model_inst (
    .sys_clk, .displaySwitchCommand, .scrollCommand, .paramStrobe, .paramData);

  always #10 sys_clk = ~sys_clk;

  task automatic endOfTest;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    errorCnt++;
    $display("mismatch at %0t: bus wait timed out", $time);
    endOfTest();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] resp;
    @(posedge sys_clk);
    awAddr <= a;
    wData <= {24'h0, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      aw = awValid && awReady;
      w = wValid && wReady;
      b = bValid;
      resp = bResp;
      @(posedge sys_clk);
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
      if (b) begin
        bReady <= 1'b0;
        chk(resp, er);
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ar, r;
    logic [31:0] data;
    logic [1:0] resp;
    @(posedge sys_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge sys_clk);
      ar = arValid && arReady;
      r = rValid;
      data = rData;
      resp = rResp;
      @(posedge sys_clk);
      if (ar) arValid <= 1'b0;
      if (r) begin
        rReady <= 1'b0;
        chk(data, exp);
        chk(resp, er);
        return;
      end
    end
    hang();
  endtask
  task automatic mem(input logic isWrite);
    @(posedge sys_clk);
    memWrite <= isWrite;
    memRead <= !isWrite;
    @(posedge sys_clk);
    memWrite <= 1'b0;
    memRead <= 1'b0;
    cyc(2);
  endtask
  // 64 frames: toggles of blocks 3..1 and frames with the cursor shown
  task automatic frames(output int t3, output int t2, output int t1, output int c);
    logic p3, p2, p1;
    t3 = 0; t2 = 0; t1 = 0; c = 0;
    cyc(2);
    @(negedge sys_clk);
    {p3, p2, p1} = {block3Visible, block2Visible, block1Visible};
    repeat (64) begin
      @(posedge sys_clk);
      framePulse <= 1'b1;
      @(posedge sys_clk);
      framePulse <= 1'b0;
      cyc(2);
      @(negedge sys_clk);
      t3 += int'(block3Visible != p3);
      t2 += int'(block2Visible != p2);
      t1 += int'(block1Visible != p1);
      c += int'(cursorVisible);
      {p3, p2, p1} = {block3Visible, block2Visible, block1Visible};
    end
  endtask

  task automatic tReset;
    for (int i = 0; i < 5; i++) rd(regs[i], 32'h0, OK);
    chk({displayOn, block1Lines}, 10'h001);
    rd(A_NO, 32'h0, ERR);
  endtask
  task automatic tReadWrite;
    logic [7:0] v [5] = '{8'h01, 8'hc6, 8'h11, 8'h22, 8'h33};
    for (int i = 0; i < 5; i++) wr(regs[i], v[i], OK);
    for (int i = 0; i < 5; i++) rd(regs[i], {24'h0, v[i]}, OK);
    wr(A_NO, 8'h5a, ERR);
    cyc(2);
    chk(block1Lines, 9'h034);
  endtask
  task automatic tStart;
    chk(block1StartAddress, 16'h2211);
    wr(A_LO, 8'h34, OK);
    cyc(2);
    chk(block1StartAddress, 16'h2211);
    wr(A_HI, 8'h12, OK);
    cyc(2);
    chk(block1StartAddress, 16'h1234);
    wr(A_LN, 8'hff, OK);
    cyc(2);
    chk(block1Lines, 9'h100);
    wStrb <= 4'h0;
    wr(A_LN, 8'h77, OK);
    wStrb <= 4'h1;
    rd(A_LN, 32'hff, OK);
  endtask
  task automatic tEnable;
    wr(A_AT, 8'h55, OK);
    wr(A_EN, 8'h00, OK);
    cyc(2);
    chk({displayOn, block1Visible, block2Visible, block3Visible, cursorVisible}, 5'h00);
    wr(A_EN, 8'h01, OK);
    cyc(2);
    chk({displayOn, block1Visible, block2Visible, block3Visible, cursorVisible}, 5'h1f);
    wr(A_AT, 8'h00, OK);
    cyc(2);
    chk({displayOn, block1Visible, block2Visible, block3Visible, cursorVisible}, 5'h10);
  endtask
  task automatic tFlash;
    int t3, t2, t1, c;
    wr(A_AT, 8'hea, OK);
    frames(t3, t2, t1, c);
    chk({t3[7:0], t2[7:0], t1[7:0], c[7:0]}, {8'd32, 8'd4, 8'd4, 8'd44});
    wr(A_AT, 8'hbf, OK);
    frames(t3, t2, t1, c);
    chk({t3[7:0], t2[7:0], t1[7:0], c[7:0]}, {8'd4, 8'd32, 8'd32, 8'd45});
  endtask
  task automatic tDual;
    wr(A_MD, 8'h01, OK);
    rd(A_MD, 32'h1, OK);
    wr(A_AT, 8'h10, OK);
    cyc(2);
    chk({block2Visible, block4Visible}, 2'b11);
    wr(A_AT, 8'h40, OK);
    cyc(2);
    chk({block3Visible, block4Visible}, 2'b10);
    wr(A_MD, 8'h00, OK);
  endtask
  task automatic tCursor;
    wr(A_AT, 8'h00, OK);
    @(posedge sys_clk);
    cursorSet <= 1'b1;
    cursorSetAddress <= 16'h00ff;
    @(posedge sys_clk);
    cursorSet <= 1'b0;
    mem(1'b0);
    chk({cursorVisible, cursorAddress}, 17'h00100);
    rd(A_AT, 32'h0, OK);
    mem(1'b1);
    chk({cursorVisible, cursorAddress}, 17'h10101);
    rd(A_AT, 32'h1, OK);
    rd(A_ST, 32'h00010103, OK);
  endtask
  task automatic tCommands;
    display_host_model_inst.send(1'b0, 24'h0000a7, 1);
    cyc(2);
    rd(A_AT, 32'ha7, OK);
    display_host_model_inst.send(1'b1, 24'h095678, 3);
    cyc(2);
    chk({block1StartAddress, 7'h0, block1Lines}, 32'h5678000a);
    rd(A_LO, 32'h78, OK);
    rd(A_HI, 32'h56, OK);
    rd(A_LN, 32'h09, OK);
  endtask
  task automatic tPowerSave;
    wr(A_EN, 8'h01, OK);
    wr(A_MD, 8'h02, OK);
    cyc(2);
    rd(A_EN, 32'h0, OK);
    chk({powerSave, displayOn}, 2'b10);
    wr(A_MD, 8'h00, OK);
    wr(A_EN, 8'h01, OK);
    cyc(2);
    chk({powerSave, displayOn}, 2'b01);
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {awValid, wValid, bReady, arValid, rReady} = '0;
    {memWrite, memRead, cursorSet, framePulse} = '0;
    {awAddr, arAddr, wData, cursorSetAddress} = '0;
    wStrb = 4'h1;
    errorCnt = 0;
    totalChecks = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    tReset();
    tReadWrite();
    tStart();
    tEnable();
    tFlash();
    tDual();
    tCursor();
    tCommands();
    tPowerSave();
    endOfTest();
  end
endmodule
`default_nettype wire
